// ===== verilog/timer16.sv
/*
  16-bit timer with byte-wide CPU access through a shared high-byte latch,
  a single- and dual-slope counter, buffered compare values and two compare output pins.
  Assumes a CPU with one read or write strobe per cycle, synchronous inputs.
*/
`timescale 1ns/1ps
module timer16 #(
  parameter int unsigned WORD_W = timer16_pkg::CNT_W
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic timer_tick,
  input wire logic [timer16_pkg::ADDR_W-1:0] addr,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_r,
  input wire logic port_out_a,
  input wire logic port_out_b,
  input wire logic dir_out_a,
  input wire logic dir_out_b,
  output logic pin_a_out_r,
  output logic pin_a_oe_r,
  output logic pin_b_out_r,
  output logic pin_b_oe_r,
  output logic [2:0] flags_r
);
  import timer16_pkg::*;

  if (WORD_W != 16) begin : g_bad_width
    $error("timer16 supports only 16-bit words");
  end

  logic [7:0] ctrl_a_r, ctrl_a_nxt, ctrl_b_r, ctrl_b_nxt, latch_r, latch_nxt, rdata_nxt;
  logic [15:0] count_r, count_nxt, cap_r, cap_nxt;
  logic [15:0] cmpa_buf_r, cmpa_buf_nxt, cmpb_buf_r, cmpb_buf_nxt;
  logic [15:0] cmpa_act_r, cmpa_act_nxt, cmpb_act_r, cmpb_act_nxt;
  logic count_up_r, count_up_nxt;
  logic [2:0] flags_nxt;
  logic pin_a_out_nxt, pin_b_out_nxt;
  logic [3:0] wsel;
  cls_t cls;
  logic [15:0] top;
  logic at_top, at_bottom, upd_cmp, wrap_evt, match_a, match_b, wave_a, wave_b;
  logic [1:0] out_mode_a, out_mode_b;

  assign out_mode_a = ctrl_a_r[MODE_A_POS +: 2];
  assign out_mode_b = ctrl_a_r[MODE_B_POS +: 2];
  assign wsel = {ctrl_b_r[WSEL_HI_POS +: 2], ctrl_a_r[WSEL_LO_POS +: 2]};
  assign cls = class_of(wsel);
  assign top = top_of(wsel, cmpa_act_r, cap_r);
  assign at_top = (count_r == top);
  assign at_bottom = (count_r == VAL_BOTTOM);
  assign match_a = (count_r == cmpa_act_r);
  assign match_b = (count_r == cmpb_act_r);
  // buffered compares refresh at top, except phase and frequency correct
  assign upd_cmp = (cls == CLS_PFC) ? at_bottom : at_top;
  always_comb begin
    case (cls)
      CLS_NONPWM: wrap_evt = (count_r == VAL_MAX);
      CLS_FAST: wrap_evt = at_top;
      default: wrap_evt = at_bottom && !count_up_r;
    endcase
  end

  // ==========================================================================
  // bus access and timer state
  always_comb begin
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    latch_nxt = latch_r;
    rdata_nxt = rdata_r;
    count_nxt = count_r;
    count_up_nxt = count_up_r;
    cap_nxt = cap_r;
    cmpa_buf_nxt = cmpa_buf_r;
    cmpb_buf_nxt = cmpb_buf_r;
    cmpa_act_nxt = cmpa_act_r;
    cmpb_act_nxt = cmpb_act_r;
    flags_nxt = flags_r;
    // counter sequencing, gated by the tick
    if (timer_tick) begin
      case (cls)
        CLS_NONPWM, CLS_FAST: count_nxt = at_top ? VAL_BOTTOM : count_r + 16'h0001;
        default: begin
          if (count_up_r && at_top) begin
            count_up_nxt = 1'b0;
            count_nxt = count_r - 16'h0001;
          end else if (!count_up_r && at_bottom) begin
            count_up_nxt = 1'b1;
            count_nxt = count_r + 16'h0001;
          end else begin
            count_nxt = count_up_r ? count_r + 16'h0001 : count_r - 16'h0001;
          end
        end
      endcase
      if (upd_cmp) begin
        cmpa_act_nxt = cmpa_buf_r;
        cmpb_act_nxt = cmpb_buf_r;
      end
      if (match_a) flags_nxt[MATCH_A_BIT] = 1'b1;
      if (match_b) flags_nxt[MATCH_B_BIT] = 1'b1;
      if (wrap_evt) flags_nxt[WRAP_BIT] = 1'b1;
    end
    if (cls == CLS_NONPWM) begin
      // unbuffered in non-pwm modes
      cmpa_act_nxt = cmpa_buf_r;
      cmpb_act_nxt = cmpb_buf_r;
    end
    if (wr_en) begin
      case (addr)
        OFS_CTRL_A: ctrl_a_nxt = wdata;
        OFS_CTRL_B: ctrl_b_nxt = wdata & 8'h18;
        // write one clears; a tick event in the same cycle wins only if the flag was not already set
        OFS_STATUS: flags_nxt = flags_r & ~wdata[2:0] | (flags_nxt & ~flags_r);
        OFS_COUNT_H, OFS_CMPA_H, OFS_CMPB_H, OFS_CAP_H: latch_nxt = wdata;
        OFS_COUNT_L: count_nxt = {latch_r, wdata};
        OFS_CMPA_L: cmpa_buf_nxt = {latch_r, wdata};
        OFS_CMPB_L: cmpb_buf_nxt = {latch_r, wdata};
        OFS_CAP_L: cap_nxt = {latch_r, wdata};
        default: latch_nxt = latch_r;
      endcase
    end
    if (rd_en) begin
      case (addr)
        OFS_CTRL_A: rdata_nxt = ctrl_a_r;
        OFS_CTRL_B: rdata_nxt = ctrl_b_r;
        OFS_STATUS: rdata_nxt = {5'h00, flags_r};
        OFS_COUNT_L: begin
          rdata_nxt = count_r[7:0];
          if (!wr_en) latch_nxt = count_r[15:8];
        end
        OFS_CAP_L: begin
          rdata_nxt = cap_r[7:0];
          if (!wr_en) latch_nxt = cap_r[15:8];
        end
        OFS_COUNT_H, OFS_CAP_H: rdata_nxt = latch_r;
        OFS_CMPA_L: rdata_nxt = cmpa_buf_r[7:0];
        OFS_CMPA_H: rdata_nxt = cmpa_buf_r[15:8];
        OFS_CMPB_L: rdata_nxt = cmpb_buf_r[7:0];
        OFS_CMPB_H: rdata_nxt = cmpb_buf_r[15:8];
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_a_r <= CTRL_RESET;
      ctrl_b_r <= CTRL_RESET;
      latch_r <= 8'h00;
      rdata_r <= 8'h00;
      count_r <= WORD_RESET;
      count_up_r <= 1'b1;
      cap_r <= WORD_RESET;
      cmpa_buf_r <= WORD_RESET;
      cmpb_buf_r <= WORD_RESET;
      cmpa_act_r <= WORD_RESET;
      cmpb_act_r <= WORD_RESET;
      flags_r <= 3'h0;
    end else begin
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      latch_r <= latch_nxt;
      rdata_r <= rdata_nxt;
      count_r <= count_nxt;
      count_up_r <= count_up_nxt;
      cap_r <= cap_nxt;
      cmpa_buf_r <= cmpa_buf_nxt;
      cmpb_buf_r <= cmpb_buf_nxt;
      cmpa_act_r <= cmpa_act_nxt;
      cmpb_act_r <= cmpb_act_nxt;
      flags_r <= flags_nxt;
    end
  end

  // ==========================================================================
  // compare output channels and pins
  compare_out_unit #(.IS_CHAN_A(1'b1)) u_out_a (
    .core_clk(core_clk), .resetn(resetn), .tick(timer_tick), .cls(cls), .out_mode_n(out_mode_a),
    .waveform_select_bit3(wsel[3]), .match(match_a), .cmp_is_top(cmpa_act_r == top),
    .at_bottom(at_bottom), .count_up(count_up_r), .wave_r(wave_a)
  );
  compare_out_unit #(.IS_CHAN_A(1'b0)) u_out_b (
    .core_clk(core_clk), .resetn(resetn), .tick(timer_tick), .cls(cls), .out_mode_n(out_mode_b),
    .waveform_select_bit3(wsel[3]), .match(match_b), .cmp_is_top(cmpb_act_r == top),
    .at_bottom(at_bottom), .count_up(count_up_r), .wave_r(wave_b)
  );

  // mode 01 in a pwm class leaves the pin to the port unless waveform bit 3 is set
  function automatic logic wave_owns(input logic [1:0] mode, input cls_t c, input logic bit3);
    wave_owns = (mode != 2'b00) && !((c != CLS_NONPWM) && (mode == 2'b01) && !bit3);
  endfunction : wave_owns

  always_comb begin
    pin_a_out_nxt = wave_owns(out_mode_a, cls, wsel[3]) ? wave_a : port_out_a;
    pin_b_out_nxt = wave_owns(out_mode_b, cls, wsel[3]) ? wave_b : port_out_b;
  end

  // pin values lag the waveform by one cycle so every output is a flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_a_out_r <= 1'b0;
      pin_b_out_r <= 1'b0;
      pin_a_oe_r <= 1'b0;
      pin_b_oe_r <= 1'b0;
    end else begin
      pin_a_out_r <= pin_a_out_nxt;
      pin_b_out_r <= pin_b_out_nxt;
      pin_a_oe_r <= dir_out_a;
      pin_b_oe_r <= dir_out_b;
    end
  end

  AST_HIGH_WRITE_LATCH: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_en && addr == OFS_CMPB_H && !rd_en |=> latch_r == $past(wdata))
    else $error("high-byte write did not load latch");
  AST_LOW_WRITE_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_en && addr == OFS_CMPA_L |=> cmpa_buf_r == {$past(latch_r), $past(wdata)})
    else $error("low-byte write did not load word");
  AST_LATCH_REUSE: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_en && addr == OFS_CAP_L && !rd_en |=> latch_r == $past(latch_r))
    else $error("low-byte write disturbed latch");
  AST_LOW_READ_COPY: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_en && !wr_en && addr == OFS_COUNT_L |=> latch_r == $past(count_r[15:8]) ##0
    rdata_r == $past(count_r[7:0]))
    else $error("low-byte read did not copy high byte");
  AST_CMP_READ_DIRECT: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_en && !wr_en && addr == OFS_CMPA_H |=> $stable(latch_r) && rdata_r == $past(cmpa_buf_r[15:8]))
    else $error("compare read touched latch");
  AST_PFC_BOTTOM_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
    timer_tick && cls == CLS_PFC && !at_bottom && !(wr_en && addr == OFS_CTRL_B)
    && !(wr_en && addr == OFS_CTRL_A) |=> $stable(cmpb_act_r))
    else $error("compare reloaded away from bottom");
  AST_IDLE_NO_COUNT: assert property (@(posedge core_clk) disable iff (!resetn)
    !timer_tick && !wr_en |=> $stable(count_r) && $stable(flags_r))
    else $error("counter moved without tick");
  AST_MATCH_FLAG: assert property (@(posedge core_clk) disable iff (!resetn)
    timer_tick && match_a |=> flags_r[MATCH_A_BIT])
    else $error("match flag not set");
  AST_PIN_ENABLE: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 pin_a_oe_r == $past(dir_out_a) && pin_b_oe_r == $past(dir_out_b))
    else $error("pin enable ignores direction");
  AST_PIN_OWNER: assert property (@(posedge core_clk) disable iff (!resetn)
    out_mode_a == 2'b00 |=> pin_a_out_r == $past(port_out_a))
    else $error("disconnected pin not from port");
  AST_PWM_DISCONNECT: assert property (@(posedge core_clk) disable iff (!resetn)
    cls != CLS_NONPWM && out_mode_a == 2'b01 && !wsel[3] |=> pin_a_out_r == $past(port_out_a))
    else $error("pwm mode 01 did not leave pin to port");
endmodule : timer16

// ===== verilog/timer16_pkg.sv
/*
  Constants, types and helper functions shared by the 16-bit timer and its
  compare output units. Assumes one 100 MHz core clock and byte-wide CPU access.
*/
package timer16_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned CNT_W = 16;
  // ==========================================================================
  // byte offsets on the CPU bus
  localparam logic [3:0] OFS_CTRL_A = 4'h0;
  localparam logic [3:0] OFS_CTRL_B = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  localparam logic [3:0] OFS_COUNT_L = 4'h4;
  localparam logic [3:0] OFS_COUNT_H = 4'h5;
  localparam logic [3:0] OFS_CMPA_L = 4'h6;
  localparam logic [3:0] OFS_CMPA_H = 4'h7;
  localparam logic [3:0] OFS_CMPB_L = 4'h8;
  localparam logic [3:0] OFS_CMPB_H = 4'h9;
  localparam logic [3:0] OFS_CAP_L = 4'hA;
  localparam logic [3:0] OFS_CAP_H = 4'hB;
  // ==========================================================================
  // field positions and reset values
  localparam int unsigned MODE_A_POS = 6;
  localparam int unsigned MODE_B_POS = 4;
  localparam int unsigned WSEL_LO_POS = 0;
  localparam int unsigned WSEL_HI_POS = 3;
  localparam int unsigned WRAP_BIT = 0;
  localparam int unsigned MATCH_A_BIT = 1;
  localparam int unsigned MATCH_B_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] VAL_BOTTOM = 16'h0000;
  localparam logic [15:0] VAL_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  // ==========================================================================
  // mode classes, gray coded
  typedef enum logic [1:0] {
    CLS_NONPWM = 2'b00,
    CLS_FAST = 2'b01,
    CLS_PC = 2'b11,
    CLS_PFC = 2'b10
  } cls_t;

  function automatic cls_t class_of(input logic [3:0] wsel);
    case (wsel)
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: class_of = CLS_FAST;
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB: class_of = CLS_PC;
      4'h8, 4'h9: class_of = CLS_PFC;
      default: class_of = CLS_NONPWM;
    endcase
  endfunction : class_of

  function automatic logic [15:0] top_of(input logic [3:0] wsel, input logic [15:0] cmp_a,
                                         input logic [15:0] cap);
    case (wsel)
      4'h1, 4'h5: top_of = TOP_8BIT;
      4'h2, 4'h6: top_of = TOP_9BIT;
      4'h3, 4'h7: top_of = TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: top_of = cmp_a;
      4'h8, 4'hA, 4'hC, 4'hE: top_of = cap;
      default: top_of = VAL_MAX;
    endcase
  endfunction : top_of
endpackage : timer16_pkg

// ===== verilog/compare_out_unit.sv
/*
  One compare output channel: holds the waveform level and applies the
  compare output mode for the current mode class on each timer tick.
  Assumes match, bottom and direction are presented with the tick.
*/
`timescale 1ns/1ps
module compare_out_unit #(
  parameter bit IS_CHAN_A = 1'b1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic tick,
  input wire timer16_pkg::cls_t cls,
  input wire logic [1:0] out_mode_n,
  input wire logic waveform_select_bit3,
  input wire logic match,
  input wire logic cmp_is_top,
  input wire logic at_bottom,
  input wire logic count_up,
  output logic wave_r
);
  import timer16_pkg::*;

  logic wave_nxt;

  // ==========================================================================
  // waveform level
  always_comb begin
    wave_nxt = wave_r;
    if (tick) begin
      case (cls)
        CLS_NONPWM: begin
          if (match) begin
            case (out_mode_n)
              2'b01: wave_nxt = ~wave_r;
              2'b10: wave_nxt = 1'b0;
              2'b11: wave_nxt = 1'b1;
              default: wave_nxt = wave_r;
            endcase
          end
        end
        CLS_FAST: begin
          if (out_mode_n == 2'b01) begin
            if (match && waveform_select_bit3 && IS_CHAN_A) wave_nxt = ~wave_r;
          end else if (out_mode_n[1]) begin
            if (at_bottom) wave_nxt = ~out_mode_n[0];
            // a compare equal to top is ignored, only bottom acts
            if (match && !cmp_is_top) wave_nxt = out_mode_n[0];
          end
        end
        CLS_PC, CLS_PFC: begin
          if (out_mode_n == 2'b01) begin
            if (match && waveform_select_bit3 && IS_CHAN_A) wave_nxt = ~wave_r;
          end else if (out_mode_n[1] && match) begin
            wave_nxt = count_up ? out_mode_n[0] : ~out_mode_n[0];
          end
        end
        default: wave_nxt = wave_r;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) wave_r <= 1'b0;
    else wave_r <= wave_nxt;
  end

  AST_NONPWM_SET: assert property (@(posedge core_clk) disable iff (!resetn)
    tick && cls == CLS_NONPWM && out_mode_n == 2'b11 && match |=> wave_r)
    else $error("set on match missed");
  AST_FAST_TOP_IGNORED: assert property (@(posedge core_clk) disable iff (!resetn)
    tick && cls == CLS_FAST && out_mode_n[1] && match && cmp_is_top && !at_bottom |=> $stable(wave_r))
    else $error("match at top acted in fast pwm");
  AST_DUAL_DOWN: assert property (@(posedge core_clk) disable iff (!resetn)
    tick && (cls == CLS_PC || cls == CLS_PFC) && out_mode_n == 2'b10 && match && !count_up |=> wave_r)
    else $error("down-count match did not set");
endmodule : compare_out_unit

// ===== sim/cpu_bus_model.sv
/*
  CPU side of the timer's byte-wide register bus: single byte accesses and
  paired 16-bit accesses. Assumes strobes are sampled on the core_clk rising edge.
*/
`timescale 1ns/1ps
module cpu_bus_model (
  input wire logic core_clk,
  input wire logic [7:0] rdata_r,
  output logic [timer16_pkg::ADDR_W-1:0] addr,
  output logic rd_en,
  output logic wr_en,
  output logic [7:0] wdata
);
  import timer16_pkg::*;
  initial begin
    addr = 4'hF;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdata = 8'h00;
  end
  // ==========================================================================
  // byte cycles
  // idle address and data show the inverse, so a stale value never matches
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : wr8

  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata_r;
  endtask : rd8
  // ==========================================================================
  // word cycles
  // single master with no interrupts, so the shared latch is never disturbed
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr8(lo + 4'h1, v[15:8]);
    wr8(lo, v[7:0]);
  endtask : wr16

  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd8(lo, v[7:0]);
    rd8(lo + 4'h1, v[15:8]);
  endtask : rd16
endmodule : cpu_bus_model

// ===== sim/timer16_tb.sv
/*
  Self-checking bench for the 16-bit timer: byte access through the shared
  latch, pin takeover and compare output modes. Assumes cpu_bus_model on the bus.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module timer16_tb;
  import timer16_pkg::*;
  logic core_clk, resetn, timer_tick, rd_en, wr_en, p;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata_r, d;
  logic port_out_a, port_out_b, dir_out_a, dir_out_b;
  logic pin_a_out_r, pin_a_oe_r, pin_b_out_r, pin_b_oe_r;
  logic [2:0] flags_r;
  logic [15:0] v;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  timer16 dut_u (.core_clk(core_clk), .resetn(resetn), .timer_tick(timer_tick), .addr(addr),
    .rd_en(rd_en), .wr_en(wr_en), .wdata(wdata), .rdata_r(rdata_r), .port_out_a(port_out_a),
    .port_out_b(port_out_b), .dir_out_a(dir_out_a), .dir_out_b(dir_out_b),
    .pin_a_out_r(pin_a_out_r), .pin_a_oe_r(pin_a_oe_r), .pin_b_out_r(pin_b_out_r),
    .pin_b_oe_r(pin_b_oe_r), .flags_r(flags_r));
  cpu_bus_model cpu_u (.core_clk(core_clk), .rdata_r(rdata_r), .addr(addr), .rd_en(rd_en),
    .wr_en(wr_en), .wdata(wdata));

  always #5 core_clk = ~core_clk;

  // whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end
  // ==========================================================================
  // helpers
  task automatic stop_test();
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  // clears the flag first, since flags are sticky
  task automatic wait_flag(input int b);
    cpu_u.wr8(OFS_STATUS, 8'h01 << b);
    cyc(1);
    for (int i = 0; i < 64 && flags_r[b] !== 1'b1; i++) cyc(1);
    `CHK("flag", 1'b1, flags_r[b])
  endtask : wait_flag
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    cpu_u.rd8(OFS_CTRL_A, d);
    `CHK("ctrl_a", CTRL_RESET, d)
    cpu_u.wr8(OFS_CTRL_B, 8'hFF);
    cpu_u.rd8(OFS_CTRL_B, d);
    `CHK("ctrl_b", 8'h18, d)
    cpu_u.wr8(OFS_CTRL_B, 8'h00);
    cpu_u.rd8(4'hC, d);
    `CHK("unmapped", 8'h00, d)
    cpu_u.wr16(OFS_COUNT_L, 16'h01FF);
    cyc(4);
    cpu_u.rd16(OFS_COUNT_L, v);
    `CHK("count", 16'h01FF, v)
    cpu_u.wr8(OFS_CMPA_H, 8'hAB);
    cpu_u.wr8(OFS_CMPA_L, 8'h11);
    cpu_u.wr8(OFS_CAP_L, 8'h22);
    cpu_u.rd16(OFS_CMPA_L, v);
    `CHK("cmp_a", 16'hAB11, v)
    cpu_u.rd16(OFS_CAP_L, v);
    `CHK("capture", 16'hAB22, v)
    cpu_u.rd8(OFS_COUNT_L, d);
    cpu_u.rd8(OFS_CMPA_H, d);
    `CHK("cmp_a_hi", 8'hAB, d)
    cpu_u.rd8(OFS_COUNT_H, d);
    `CHK("latch", 8'h01, d)
  endtask : t_regs

  task automatic t_port();
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      port_out_a <= i[0];
      dir_out_a <= i[1];
      port_out_b <= ~i[0];
      dir_out_b <= ~i[1];
      cyc(3);
      `CHK("pin_a", i[0], pin_a_out_r)
      `CHK("oe_a", i[1], pin_a_oe_r)
      `CHK("pin_b", ~i[0], pin_b_out_r)
      `CHK("oe_b", ~i[1], pin_b_oe_r)
    end
  endtask : t_port

  // port level is set opposite to the expected wave to prove the takeover
  task automatic t_ctc();
    logic [1:0] m;
    cpu_u.wr16(OFS_COUNT_L, 16'h0000);
    cpu_u.wr16(OFS_CMPA_L, 16'h0007);
    cpu_u.wr16(OFS_CMPB_L, 16'h0004);
    cpu_u.wr8(OFS_CTRL_B, 8'h08);
    @(posedge core_clk);
    timer_tick <= 1'b1;
    dir_out_a <= 1'b1;
    dir_out_b <= 1'b1;
    for (int k = 3; k >= 1; k--) begin
      m = k[1:0];
      @(posedge core_clk);
      port_out_a <= ~m[0];
      port_out_b <= ~m[0];
      cpu_u.wr8(OFS_CTRL_A, {m, m, 4'h0});
      wait_flag(MATCH_A_BIT);
      cyc(2);
      p = pin_a_out_r;
      wait_flag(MATCH_A_BIT);
      cyc(2);
      `CHK("wave_a", (k == 1) ? ~p : m[0], pin_a_out_r)
      wait_flag(MATCH_B_BIT);
      cyc(2);
      if (k > 1) `CHK("wave_b", m[0], pin_b_out_r)
    end
    @(posedge core_clk);
    dir_out_a <= 1'b0;
    cyc(3);
    `CHK("oe_a_wave", 1'b0, pin_a_oe_r)
    @(posedge core_clk);
    dir_out_a <= 1'b1;
  endtask : t_ctc

  task automatic t_fast();
    logic [1:0] m;
    cpu_u.wr8(OFS_CTRL_B, 8'h18);
    for (int k = 2; k < 4; k++) begin
      m = k[1:0];
      cpu_u.wr8(OFS_CTRL_A, {m, m, 4'h3});
      // the mode switch may leave the count above top, which would run to max
      cpu_u.wr16(OFS_COUNT_L, 16'h0000);
      wait_flag(WRAP_BIT);
      cyc(2);
      `CHK("bottom_b", ~m[0], pin_b_out_r)
      `CHK("top_a", ~m[0], pin_a_out_r)
      wait_flag(MATCH_B_BIT);
      cyc(2);
      `CHK("match_b", m[0], pin_b_out_r)
      `CHK("top_a", ~m[0], pin_a_out_r)
    end
    cpu_u.wr8(OFS_CTRL_A, 8'h43);
    wait_flag(MATCH_A_BIT);
    cyc(2);
    p = pin_a_out_r;
    wait_flag(MATCH_A_BIT);
    cyc(2);
    `CHK("toggle_a", ~p, pin_a_out_r)
    cpu_u.wr8(OFS_CTRL_B, 8'h08);
    cpu_u.wr8(OFS_CTRL_A, 8'h41);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      port_out_a <= i[0];
      cyc(3);
      `CHK("port_a", i[0], pin_a_out_r)
    end
  endtask : t_fast

  // the wrap flag marks bottom, so the next match is on the up slope
  // mode 10 runs phase and frequency correct, mode 11 phase correct
  task automatic t_dual();
    logic [1:0] m;
    cpu_u.wr8(OFS_CTRL_B, 8'h10);
    for (int k = 2; k < 4; k++) begin
      m = k[1:0];
      cpu_u.wr8(OFS_CTRL_A, {2'b00, m, 2'b00, m[0], 1'b1});
      cpu_u.wr16(OFS_COUNT_L, 16'h0000);
      wait_flag(WRAP_BIT);
      wait_flag(MATCH_B_BIT);
      cyc(2);
      `CHK("up_match", m[0], pin_b_out_r)
      wait_flag(MATCH_B_BIT);
      cyc(2);
      `CHK("down_match", ~m[0], pin_b_out_r)
    end
  endtask : t_dual
  // ==========================================================================
  // main sequence
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    timer_tick = 1'b0;
    port_out_a = 1'b0;
    port_out_b = 1'b0;
    dir_out_a = 1'b0;
    dir_out_b = 1'b0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_port();
    t_ctc();
    t_fast();
    t_dual();
    stop_test();
  end
endmodule : timer16_tb
